// [src/cprc_pkg.sv]
/*
 * Shared constants for the clock, power-save and reset control block:
 * register offsets, field positions, reset values and cycle counts.
 * Assumes a 40 MHz reference clock and a 32-bit Avalon-MM register port.
 */
package cprc_pkg;

    // Register byte offsets
    localparam logic [3:0] CPRC_CTRL_OFS = 4'h0;
    localparam logic [3:0] CPRC_STATUS_OFS = 4'h4;
    localparam logic [3:0] CPRC_STRAP_OFS = 4'h8;

    // Control register fields
    localparam int CPRC_CTRL_PRI_OE = 0;
    localparam int CPRC_CTRL_SEC_OE = 1;
    localparam int CPRC_CTRL_PRI_XTAL = 2;
    localparam int CPRC_CTRL_SEC_XTAL = 3;
    localparam int CPRC_CTRL_PSAVE = 4;
    localparam int CPRC_CTRL_DIV_LSB = 5;
    localparam int CPRC_CTRL_W = 8;
    localparam logic [7:0] CPRC_CTRL_RESET = 8'h23;

    // Status register fields
    localparam int CPRC_STAT_PSAVE = 0;
    localparam int CPRC_STAT_RUN = 1;
    localparam int CPRC_STAT_LOCK = 2;
    localparam int CPRC_STAT_SHORT = 3;

    localparam logic [19:0] CPRC_RESET_VECTOR = 20'hF_FFF0;
    localparam logic [15:0] CPRC_STRAP_RESET = 16'h0000;

    // Timing
    localparam int CPRC_CLK_PERIOD_NS = 25;
    localparam int CPRC_RES_HOLD_MS = 1;
    localparam int CPRC_RES_HOLD_CYCLES =
        (CPRC_RES_HOLD_MS * 1_000_000 + CPRC_CLK_PERIOD_NS - 1) / CPRC_CLK_PERIOD_NS;
    localparam int CPRC_LOCK_CYCLES = 16;
    localparam int CPRC_SETTLE_CYCLES = 8;

    typedef enum logic [1:0] {
        CPRC_ST_LOCK,
        CPRC_ST_HELD,
        CPRC_ST_SETTLE,
        CPRC_ST_RUN
    } cprc_rst_state_type;

endpackage

// [src/cprc_clk_div.sv]
/*
 * Processor clock divider: emits one tick per divided period and a
 * square-wave phase that toggles on every tick.
 * Assumes run is low until the clock source is stable.
 */
module cprc_clk_div
    import cprc_pkg::*;
#(
    parameter int SEL_W = 3
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Control
    input wire logic run,
    input wire logic [SEL_W-1:0] div_sel,
    // Outputs
    output logic tick,
    output logic phase
);

    localparam int CNT_W = (1 << SEL_W);

    if (SEL_W < 1 || SEL_W > 4) begin : g_bad_sel
        $error("cprc_clk_div: SEL_W must be 1 to 4");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic phase_r;
    logic phase_nxt;

    assign tick = run && clk_en && (cnt_r == '0);
    assign phase = phase_r;

    // A new divisor is taken only at a period boundary, so no phase is cut short
    always_comb begin
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        if (!run) begin
            cnt_nxt = '0;
            phase_nxt = 1'b0;
        end else if (cnt_r == '0) begin
            cnt_nxt = CNT_W'((1 << div_sel) - 1);  // RL18
            phase_nxt = !phase_r;
        end else begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (clk_en) begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    AST_NO_SHORT_PERIOD: assert property (@(posedge ref_clk) disable iff (!resetn || !clk_en)
        tick && run && div_sel != '0 |=> !tick)  // RL18
        else $error("divider ticked twice in a row with a divisor above one");

endmodule

// [src/cprc_ctrl.sv]
/*
 * Clock, power-save and reset control: two clock outputs with drive
 * enables and source select, an automatic power-save exit on interrupt,
 * reset sequencing and capture of bus straps, all behind Avalon-MM.
 * Assumes all inputs are synchronous to ref_clk; resetn is power-on reset.
 * Clock outputs are modelled as registered square waves at half the tick rate, or at half the ref_clk rate on the crystal source.
 */
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
// Summary of operation
// RL1 - Undivided processor clock runs at the crystal rate, no double oscillator.
// RL2 - Clock generation held off until power-on reset and lock delay end.
// RL3 - Each clock output selects processor rate or undivided crystal rate.
// RL4 - Each clock output driver has its own enable.
// RL5 - One output may run at crystal rate while the other runs slowed.
// RL6 - Power-save keeps CPU and peripherals ticking from a slower divided clock.
// RL7 - Interrupt at a t3 rising edge leaves power-save without software.
// RL8 - Interrupt request must be valid before that t3 edge.
// RL9 - Software reprograms clock-dependent peripherals after frequency changes.
// RL10 - Reset pin must be held low at least 1 ms at power-up; a shorter first hold is only flagged.
// RL11 - While reset pin is low, no execution, fetch or bus cycle.
// RL12 - After release and settling, fetching starts at vector FFFF0h.
// RL13 - While reset pin is low, the 16-bit bus is sampled into a register.
// RL14 - Multiplexed bus stays undriven through reset.
// RL15 - Board presents straps by weak resistors or a reset-only driver.
// RL16 - Captured strap value is readable by software.
// RL17 - Strap register is read-only and keeps the last value sampled.
// RL18 - Switching between normal and slowed clock leaves no short pulse.
module cprc_ctrl
    import cprc_pkg::*;
#(
    parameter int DIV_SEL_W = 3,
    parameter int STRAP_W = 16,
    parameter int LOCK_CYCLES = CPRC_LOCK_CYCLES,
    parameter int SETTLE_CYCLES = CPRC_SETTLE_CYCLES,
    parameter int RES_HOLD_CYCLES = CPRC_RES_HOLD_CYCLES
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Reset pin and strap bus
    input wire logic reset_input_low,
    input wire logic [STRAP_W-1:0] muxed_addr_data_bus_in,
    output logic muxed_addr_data_bus_oe,
    // Bus timing and interrupt
    input wire logic bus_t3_edge,
    input wire logic irq_valid,
    // Clock outputs
    output logic primary_clock_out,
    output logic primary_clock_out_oe,
    output logic secondary_clock_out,
    output logic secondary_clock_out_oe,
    // Processor control
    output logic proc_tick,
    output logic cpu_halt,
    output logic cpu_start,
    output logic [19:0] fetch_addr,
    output logic psave_active
);

    localparam int AST_SETTLE_MAX = 64;

    if (DIV_SEL_W != 3 || STRAP_W != 16) begin : g_bad_width
        $error("cprc_ctrl: divider select must be 3 bits and strap bus 16 bits");
    end
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 60) begin : g_bad_cnt
        $error("cprc_ctrl: lock or settle count out of range");
    end
    if (RES_HOLD_CYCLES < 1 || RES_HOLD_CYCLES > 65535) begin : g_bad_hold
        $error("cprc_ctrl: reset hold count out of range");
    end

    // Register interface state
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [CPRC_CTRL_W-1:0] ctrl_r;
    logic [CPRC_CTRL_W-1:0] ctrl_nxt;
    logic [STRAP_W-1:0] strap_r;
    logic [STRAP_W-1:0] strap_nxt;
    logic wr_ctrl;
    logic ps_exit;

    // Reset sequencing state
    cprc_rst_state_type st_r;
    cprc_rst_state_type st_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] hold_r;
    logic [15:0] hold_nxt;
    logic first_r;
    logic first_nxt;
    logic short_r;
    logic short_nxt;
    logic start_r;
    logic start_nxt;

    // Clock output state
    logic xtal_r;
    logic xtal_nxt;
    logic pri_r;
    logic pri_nxt;
    logic sec_r;
    logic sec_nxt;
    logic pri_oe_r;
    logic pri_oe_nxt;
    logic sec_oe_r;
    logic sec_oe_nxt;

    logic pll_run;
    logic div_tick;
    logic div_phase;
    logic [DIV_SEL_W-1:0] div_sel;
    logic running;

    assign pll_run = (st_r != CPRC_ST_LOCK);  // RL2
    assign running = (st_r == CPRC_ST_RUN) && reset_input_low;
    assign div_sel = ctrl_r[CPRC_CTRL_PSAVE]
        ? ctrl_r[CPRC_CTRL_DIV_LSB +: DIV_SEL_W] : '0;  // RL1 RL6

    cprc_clk_div #(
        .SEL_W(DIV_SEL_W)
    ) u_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .run(pll_run),
        .div_sel(div_sel),
        .tick(div_tick),
        .phase(div_phase)
    );

    // Avalon-MM: one wait cycle, then the answer; addresses other than 0h, 4h and 8h are unmapped
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;
    assign wr_ctrl = avs_write && ack_r && avs_byteenable[0] && (avs_address == CPRC_CTRL_OFS);
    assign ps_exit = ctrl_r[CPRC_CTRL_PSAVE] && irq_valid && bus_t3_edge;  // RL7 RL8

    always_comb begin
        ack_nxt = (avs_read || avs_write) && !ack_r;
        rdata_nxt = rdata_r;
        if (ack_nxt && avs_read) begin
            if (avs_address == CPRC_CTRL_OFS) begin
                rdata_nxt = {24'h00_0000, ctrl_r};
            end else if (avs_address == CPRC_STATUS_OFS) begin
                rdata_nxt = 32'h0000_0000;
                rdata_nxt[CPRC_STAT_PSAVE] = ctrl_r[CPRC_CTRL_PSAVE];  // RL9
                rdata_nxt[CPRC_STAT_RUN] = running;
                rdata_nxt[CPRC_STAT_LOCK] = pll_run;
                rdata_nxt[CPRC_STAT_SHORT] = short_r;
            end else if (avs_address == CPRC_STRAP_OFS) begin
                rdata_nxt = {16'h0000, strap_r};  // RL16
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    // Control register; the interrupt exit clears the power-save bit even when a write in the same cycle sets it
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (!reset_input_low) begin
            ctrl_nxt = CPRC_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_nxt = avs_writedata[CPRC_CTRL_W-1:0];  // RL4 RL3 RL5
            end
            if (ps_exit) begin
                ctrl_nxt[CPRC_CTRL_PSAVE] = 1'b0;  // RL7
            end
        end
    end

    // Straps follow the bus for as long as the pin is low, then hold
    always_comb begin
        strap_nxt = strap_r;
        if (!reset_input_low) begin
            strap_nxt = muxed_addr_data_bus_in;  // RL13 RL17
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= CPRC_CTRL_RESET;
            strap_r <= CPRC_STRAP_RESET;
        end else if (clk_en) begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            strap_r <= strap_nxt;
        end
    end

    // Reset sequencer: lock delay, pin held, settle, run
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        hold_nxt = hold_r;
        first_nxt = first_r;
        short_nxt = short_r;
        start_nxt = 1'b0;
        if (!reset_input_low && hold_r != 16'hFFFF) begin
            hold_nxt = hold_r + 1'b1;
        end
        case (st_r)
            CPRC_ST_LOCK: begin
                if (cnt_r == 16'(LOCK_CYCLES - 1)) begin
                    st_nxt = CPRC_ST_HELD;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            CPRC_ST_HELD: begin
                if (reset_input_low) begin
                    // Power-up hold shorter than the minimum is flagged, not enforced
                    if (first_r && hold_r < 16'(RES_HOLD_CYCLES)) begin
                        short_nxt = 1'b1;  // RL10
                    end
                    first_nxt = 1'b0;
                    st_nxt = CPRC_ST_SETTLE;
                    cnt_nxt = '0;
                end
            end
            CPRC_ST_SETTLE: begin
                if (!reset_input_low) begin
                    st_nxt = CPRC_ST_HELD;
                    hold_nxt = '0;
                end else if (cnt_r == 16'(SETTLE_CYCLES - 1)) begin
                    st_nxt = CPRC_ST_RUN;
                    start_nxt = 1'b1;  // RL12
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            CPRC_ST_RUN: begin
                if (!reset_input_low) begin
                    st_nxt = CPRC_ST_HELD;  // RL11
                    hold_nxt = '0;
                end
            end
            default: begin
                st_nxt = CPRC_ST_LOCK;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= CPRC_ST_LOCK;
            cnt_r <= '0;
            hold_r <= '0;
            first_r <= 1'b1;
            short_r <= 1'b0;
            start_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            first_r <= first_nxt;
            short_r <= short_nxt;
            start_r <= start_nxt;
        end
    end

    // Clock outputs: crystal phase toggles every cycle, processor phase per tick
    always_comb begin
        xtal_nxt = pll_run ? !xtal_r : 1'b0;  // RL1
        pri_nxt = ctrl_r[CPRC_CTRL_PRI_XTAL] ? xtal_r : div_phase;  // RL3 RL5
        sec_nxt = ctrl_r[CPRC_CTRL_SEC_XTAL] ? xtal_r : div_phase;  // RL3 RL5
        pri_oe_nxt = ctrl_r[CPRC_CTRL_PRI_OE];  // RL4
        sec_oe_nxt = ctrl_r[CPRC_CTRL_SEC_OE];  // RL4
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            xtal_r <= 1'b0;
            pri_r <= 1'b0;
            sec_r <= 1'b0;
            pri_oe_r <= 1'b0;
            sec_oe_r <= 1'b0;
        end else if (clk_en) begin
            xtal_r <= xtal_nxt;
            pri_r <= pri_nxt;
            sec_r <= sec_nxt;
            pri_oe_r <= pri_oe_nxt;
            sec_oe_r <= sec_oe_nxt;
        end
    end

    assign primary_clock_out = pri_r;
    assign secondary_clock_out = sec_r;
    assign primary_clock_out_oe = pri_oe_r;
    assign secondary_clock_out_oe = sec_oe_r;
    // CPU and peripherals are enabled by the divided tick, stopped only while not running
    assign proc_tick = div_tick && running;  // RL6 RL11
    assign cpu_halt = !running;  // RL11
    assign cpu_start = start_r;
    assign fetch_addr = CPRC_RESET_VECTOR;  // RL12
    assign muxed_addr_data_bus_oe = running;  // RL14
    assign psave_active = ctrl_r[CPRC_CTRL_PSAVE];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn || !clk_en);

    sequence s_release;
        (st_r == CPRC_ST_HELD) && reset_input_low;
    endsequence

    sequence s_ctrl_write(int bit_pos, logic val);
        wr_ctrl && !ps_exit && avs_writedata[bit_pos] == val;
    endsequence

    AST_PLL_HELD: assert property (st_r == CPRC_ST_LOCK |-> !proc_tick && !xtal_nxt)  // RL2
        else $error("clock ran before the lock delay ended");
    AST_FULL_RATE: assert property ((proc_tick && !psave_active) ##1 (running && !psave_active) |-> proc_tick)  // RL1
        else $error("processor tick missing at full rate");
    AST_PRI_OE_OFF: assert property (s_ctrl_write(CPRC_CTRL_PRI_OE, 1'b0) ##0 reset_input_low  // RL4
        |-> ##2 !primary_clock_out_oe)
        else $error("primary clock driver not disabled");
    AST_SEC_XTAL: assert property (ctrl_r[CPRC_CTRL_SEC_XTAL] && $stable(ctrl_r) && pll_run
        |=> secondary_clock_out == $past(xtal_r))  // RL3
        else $error("secondary clock not on crystal source");
    AST_PS_EXIT: assert property (ps_exit && reset_input_low |=> !psave_active)  // RL7
        else $error("power-save not left on interrupt at t3");
    AST_PS_TICKS: assert property (psave_active && running |-> ##[0:256] (proc_tick || !running || !psave_active))  // RL6
        else $error("processor stopped in power-save");
    AST_HALT_IN_RESET: assert property (!reset_input_low |-> cpu_halt && !muxed_addr_data_bus_oe && !proc_tick)  // RL11
        else $error("activity while reset pin low");
    AST_NO_DRIVE: assert property (st_r != CPRC_ST_RUN |-> !muxed_addr_data_bus_oe)  // RL14
        else $error("bus driven during reset");
    AST_START_VECTOR: assert property (s_release ##1 (reset_input_low [*2])  // RL12
        |-> ##[0:AST_SETTLE_MAX] (cpu_start && fetch_addr == CPRC_RESET_VECTOR) || !reset_input_low)
        else $error("fetch did not start at reset vector");
    AST_STRAP_CAPTURE: assert property (resetn && !reset_input_low  // RL13
        |=> strap_r == $past(muxed_addr_data_bus_in))
        else $error("strap value not captured");
    AST_STRAP_RO: assert property (reset_input_low |=> $stable(strap_r))  // RL17
        else $error("strap register changed outside reset");

endmodule

// [tb/cprc_board_model.sv]
/*
 * Board side of the clock and reset block: the reset pin source and the
 * strap driver on the multiplexed bus.
 * Assumes the bench pulses hold_req for one cycle to request a reset pulse.
 */
module cprc_board_model #(
    parameter int HOLD_CYCLES = 24,
    parameter int POWERUP_CYCLES = 40
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bench control
    input wire logic hold_req,
    input wire logic [15:0] strap_value,
    // Pins
    input wire logic bus_oe,
    output logic reset_input_low,
    output logic [15:0] muxed_addr_data_bus
);
    timeunit 1ns;
    timeprecision 100ps;

    int hold_cnt = POWERUP_CYCLES;
    logic [15:0] noise_r = 16'h0000;

    // Pin stays low a full hold span, counted only once power-on reset is over
    always @(posedge ref_clk) begin
        noise_r <= noise_r + 16'h3A5B;
        if (hold_req)
            hold_cnt <= HOLD_CYCLES;
        else if (resetn && hold_cnt != 0)
            hold_cnt <= hold_cnt - 1;
    end

    assign reset_input_low = (hold_cnt == 0);
    // Strap driver is enabled only in reset; afterwards the bus shows changing junk
    assign muxed_addr_data_bus = !reset_input_low ? strap_value : (bus_oe ? noise_r : ~noise_r);
endmodule

// [tb/tb_cprc_ctrl.sv]
/*
 * Self-checking bench for cprc_ctrl: register access over Avalon-MM,
 * clock outputs, power-save exit and reset pin handling.
 * Assumes the board model supplies the reset pin and strap values.
 */
module tb_cprc_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SETTLE = cprc_pkg::CPRC_SETTLE_CYCLES;
    logic ref_clk, resetn, clk_en, avs_read, avs_write, bus_t3_edge, irq_valid, hold_req;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic avs_waitrequest, reset_input_low, muxed_addr_data_bus_oe, psave_active;
    logic [15:0] muxed_addr_data_bus_in, strap_value;
    logic primary_clock_out, primary_clock_out_oe, secondary_clock_out, secondary_clock_out_oe;
    logic proc_tick, cpu_halt, cpu_start;
    logic [19:0] fetch_addr;
    logic [31:0] rng = 32'h0000_003C;
    int num_errors = 0;
    int total_checks = 0;
    int ctrl_model = 32'h0000_0023;
    int strap_q[$];

    cprc_ctrl #(.RES_HOLD_CYCLES(20)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .reset_input_low(reset_input_low), .muxed_addr_data_bus_in(muxed_addr_data_bus_in),
        .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe), .bus_t3_edge(bus_t3_edge),
        .irq_valid(irq_valid), .primary_clock_out(primary_clock_out),
        .primary_clock_out_oe(primary_clock_out_oe), .secondary_clock_out(secondary_clock_out),
        .secondary_clock_out_oe(secondary_clock_out_oe), .proc_tick(proc_tick),
        .cpu_halt(cpu_halt), .cpu_start(cpu_start), .fetch_addr(fetch_addr),
        .psave_active(psave_active)
    );

    cprc_board_model #(.HOLD_CYCLES(24), .POWERUP_CYCLES(40)) board_u (
        .ref_clk(ref_clk), .resetn(resetn), .hold_req(hold_req), .strap_value(strap_value),
        .bus_oe(muxed_addr_data_bus_oe), .reset_input_low(reset_input_low),
        .muxed_addr_data_bus(muxed_addr_data_bus_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic bit near(input int seen, input int exp);
        return (seen >= exp - 1) && (seen <= exp + 1);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks made %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Holds the request until the edge that sees waitrequest low
    task automatic av_req(input bit wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdat = avs_readdata;
        check(n < 50, 1'b1, "bus answer");
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        av_req(1'b0, a, 32'h0000_0000, 4'hF);
        check(rdat, exp, what);
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (reset_input_low !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (cpu_start !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(n >= SETTLE - 1 && n <= SETTLE + 3, 1'b1, "settle span");
        check(fetch_addr, 20'hF_FFF0, "fetch vector");
        @(posedge ref_clk);
        #1;
        check(cpu_start, 1'b0, "start pulse length");
        check(cpu_halt, 1'b0, "halt after start");
    endtask

    task automatic in_reset(input string what);
        check(cpu_halt, 1'b1, what);
        check(muxed_addr_data_bus_oe, 1'b0, what);
        rd(cprc_pkg::CPRC_STRAP_OFS, strap_q[$], what);
    endtask

    task automatic clocks();
        int tp, ts, tk, i, pt;
        logic lp, ls;
        pt = 64 >> (ctrl_model[4] ? ((ctrl_model >> 5) & 7) : 0);
        repeat (16) @(posedge ref_clk);
        #1;
        lp = primary_clock_out;
        ls = secondary_clock_out;
        tp = 0;
        ts = 0;
        tk = 0;
        for (i = 0; i < 64; i++) begin
            @(posedge ref_clk);
            #1;
            tp += (primary_clock_out !== lp);
            ts += (secondary_clock_out !== ls);
            tk += (proc_tick === 1'b1);
            lp = primary_clock_out;
            ls = secondary_clock_out;
        end
        check(primary_clock_out_oe, ctrl_model[0], "primary enable");
        check(secondary_clock_out_oe, ctrl_model[1], "secondary enable");
        check(psave_active, ctrl_model[4], "power-save level");
        check(near(tk, pt), 1'b1, "tick rate");
        if (ctrl_model[0])
            check(near(tp, ctrl_model[2] ? 64 : pt), 1'b1, "primary rate");
        if (ctrl_model[1])
            check(near(ts, ctrl_model[3] ? 64 : pt), 1'b1, "secondary rate");
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        bus_t3_edge = 1'b0;
        irq_valid = 1'b0;
        hold_req = 1'b0;
        strap_value = 16'(next_rand());
        strap_q.push_back(strap_value);
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        in_reset("power-up hold");
        rd(cprc_pkg::CPRC_CTRL_OFS, ctrl_model, "control default");
        wait_run();
        $display("test power-up done");

        rd(cprc_pkg::CPRC_STATUS_OFS, 32'h0000_0006, "status running");
        av_req(1'b1, cprc_pkg::CPRC_STRAP_OFS, 32'h0000_FFFF, 4'hF);
        rd(cprc_pkg::CPRC_STRAP_OFS, strap_q[$], "strap read only");
        av_req(1'b1, cprc_pkg::CPRC_STATUS_OFS, 32'h0000_00FF, 4'hF);
        av_req(1'b1, 4'hC, 32'h0000_00FF, 4'hF);
        rd(4'hC, 32'h0000_0000, "unmapped read");
        av_req(1'b1, cprc_pkg::CPRC_CTRL_OFS, 32'h0000_0013, 4'hE);
        rd(cprc_pkg::CPRC_CTRL_OFS, ctrl_model, "lane 0 disabled");
        $display("test registers done");

        for (int i = 0; i < 32; i++) begin
            ctrl_model = ((next_rand() & 3) << 5) | i;
            av_req(1'b1, cprc_pkg::CPRC_CTRL_OFS, ctrl_model, 4'h1);
            rd(cprc_pkg::CPRC_CTRL_OFS, ctrl_model, "control readback");
            clocks();
        end
        $display("test clock outputs done");

        ctrl_model = 32'h0000_0033;
        av_req(1'b1, cprc_pkg::CPRC_CTRL_OFS, ctrl_model, 4'hF);
        @(posedge ref_clk);
        bus_t3_edge <= 1'b1;
        @(posedge ref_clk);
        bus_t3_edge <= 1'b0;
        irq_valid <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        check(psave_active, 1'b1, "no exit without t3 edge");
        rd(cprc_pkg::CPRC_STATUS_OFS, 32'h0000_0007, "status in power-save");
        @(posedge ref_clk);
        bus_t3_edge <= 1'b1;
        @(posedge ref_clk);
        bus_t3_edge <= 1'b0;
        irq_valid <= 1'b0;
        #1;
        check(psave_active, 1'b0, "exit at t3 edge");
        ctrl_model = 32'h0000_0023;
        rd(cprc_pkg::CPRC_CTRL_OFS, ctrl_model, "bit cleared by exit");
        rd(cprc_pkg::CPRC_STATUS_OFS, 32'h0000_0006, "status after exit");
        $display("test power-save exit done");

        av_req(1'b1, cprc_pkg::CPRC_CTRL_OFS, 32'h0000_001F, 4'hF);
        @(posedge ref_clk);
        strap_value <= 16'(next_rand());
        hold_req <= 1'b1;
        @(posedge ref_clk);
        hold_req <= 1'b0;
        strap_q.push_back(strap_value);
        repeat (3) @(posedge ref_clk);
        #1;
        in_reset("mid-run hold");
        wait_run();
        rd(cprc_pkg::CPRC_CTRL_OFS, 32'h0000_0023, "control restored");
        rd(cprc_pkg::CPRC_STRAP_OFS, strap_q[$], "new strap kept");
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
